// ==== hw/fsa_consts.svh ====
// Fault codes, channel angle tables and timing constants for the fault state aggregator
`ifndef FSA_CONSTS_SVH
`define FSA_CONSTS_SVH

`define FSA_NUM_FAULTS      17
`define FSA_NUM_CHANNELS    16
`define FSA_CLK_MHZ         250
`define FSA_IMU_SETTLE_S    30
`define FSA_RECOVERY_S      120
`define FSA_IMU_SETTLE_CYC  (`FSA_IMU_SETTLE_S * `FSA_CLK_MHZ * 64'd1000000)
`define FSA_RECOVERY_CYC    (`FSA_RECOVERY_S * `FSA_CLK_MHZ * 64'd1000000)

// Fault index positions on the fault input vector
`define FSA_IDX_LENS        0
`define FSA_IDX_TEMP_A      1
`define FSA_IDX_TEMP_B      2
`define FSA_IDX_IMU         3
`define FSA_IDX_INLET       4
`define FSA_IDX_PARAM       5
`define FSA_IDX_MOT_SPEED   6
`define FSA_IDX_MOT_STALL   7
`define FSA_IDX_MOT_OVERI   8
`define FSA_IDX_ENC_OUT     9
`define FSA_IDX_ENC_DISK    10
`define FSA_IDX_BOOT        11
`define FSA_IDX_PPS_ACC     12
`define FSA_IDX_NAV_LOSS    13
`define FSA_IDX_PPS_LOSS    14
`define FSA_IDX_NAV_BAD     15
`define FSA_IDX_EYE         16

// Fault codes, one per index
`define FSA_CODE_TABLE {16'h0104, 16'h0111, 16'h0112, 16'h0113, 16'h0116, 16'h0117, 16'h0210, 16'h0211, \
                        16'h0212, 16'h0213, 16'h0214, 16'h0215, 16'h0406, 16'h0407, 16'h0408, 16'h0409, \
                        16'h0501}
// Shutdown class mask, bit i set means index i is Shutdown
`define FSA_SHUTDOWN_MASK   17'h00B96
// Faults latched until restart
`define FSA_STICKY_MASK     17'h10010
// Scanning module faults with self-recovery
`define FSA_RECOVER_MASK    17'h005C0

// Design angles in hundredths of a degree, channel 1 first
`define FSA_AZIMUTH_TABLE   {16'h4B95, 16'h4B9C, 16'h4B99, 16'h4B9C, 16'h4BA4, 16'h4BA7, 16'h4BAD, 16'h4BB6, \
                             16'h497A, 16'h4978, 16'h4985, 16'h4984, 16'h4987, 16'h498A, 16'h498D, 16'h498F}
`define FSA_ELEVATION_TABLE {16'h0001, 16'h010C, 16'h021D, 16'h0329, 16'h0431, 16'h053B, 16'h0644, 16'h074F, \
                             16'h0859, 16'h0962, 16'h0A6D, 16'h0B77, 16'h0C81, 16'h0D8E, 16'h0E9E, 16'h0FB5}

`endif

// ==== hw/fsa_pkg.sv ====
// Types for the fault state aggregator
package fsa_pkg;

  typedef enum logic [1:0] {
    FSA_NORMAL   = 2'b00,
    FSA_WARNING  = 2'b01,
    FSA_SHUTDOWN = 2'b10
  } fsa_state_t;

  typedef struct packed {
    logic [15:0] code;
    fsa_state_t  health;
    logic        valid;
  } fsa_report_t;

  typedef struct packed {
    logic [4:0]  number;
    logic [15:0] azimuth;
    logic [15:0] elevation;
  } fsa_angle_t;

endpackage : fsa_pkg

// ==== hw/fsa_fault_state_aggregator.sv ====
// Fault state aggregator: fault codes, health state and channel design angles
// Contract
// [RL1] Channels are numbered from one at the bottom upward.
// [RL2] Hold design azimuth and elevation per channel; calibration may override.
// [RL3] Health state equals the class of the most severe active fault.
// [RL4] Cover lens contamination reports code 0x0104 as Warning.
// [RL5] Overtemperature A and B report distinct codes, both Shutdown.
// [RL6] IMU malfunction is Warning and may clear itself within thirty seconds.
// [RL7] Inlet voltage abnormality is Shutdown and latched until restart.
// [RL8] Motor speed Warning, stall and overcurrent Shutdown, all self-recovering.
// [RL9] Self-recovering scan faults get 120 s, then become persistent.
// [RL10] Low PPS synchronisation accuracy is a Warning with its own code.
// [RL11] Navigation data loss and bad navigation content are separate Warnings.
// [RL12] PPS input loss is a Warning with its own code.
// [RL13] Eye safety risk disables all lasers until restart, reported as Warning.
// [RL14] Shutdown ranks above Warning; no fault gives Normal.
// [RL15] Parameter fault Warning; encoder output and boot failure Shutdown, no recovery.
`timescale 1ns/100ps
`include "fsa_consts.svh"

module fsa_fault_state_aggregator
  import fsa_pkg::*;
#(
  parameter int          NUM_FAULTS   = `FSA_NUM_FAULTS,
  parameter int          NUM_CHANNELS = `FSA_NUM_CHANNELS,
  parameter logic [63:0] IMU_SETTLE   = `FSA_IMU_SETTLE_CYC,
  parameter logic [63:0] RECOVERY     = `FSA_RECOVERY_CYC
) (
  // Clock and reset
  input  wire logic            ref_clk,
  input  wire logic            sys_rst,
  // Raw fault conditions
  input  wire logic [16:0]     fault_in,
  // Channel angle lookup
  input  wire logic [4:0]      chan_sel,
  output fsa_angle_t           chan_angle,
  // Report selection and result
  input  wire logic [4:0]      report_sel,
  output fsa_report_t          report,
  // Summary outputs
  output logic [16:0]          fault_active,
  output logic [16:0]          fault_persistent,
  output fsa_state_t           health,
  output logic                 laser_en,
  output logic                 fault_event
);

  localparam logic [16*17-1:0] CODES   = `FSA_CODE_TABLE;
  localparam logic [16*16-1:0] AZ_TAB  = `FSA_AZIMUTH_TABLE;
  localparam logic [16*16-1:0] EL_TAB  = `FSA_ELEVATION_TABLE;
  localparam logic [16:0]      SHUT    = `FSA_SHUTDOWN_MASK;
  localparam logic [16:0]      STICKY  = `FSA_STICKY_MASK;
  localparam logic [16:0]      RECOVER = `FSA_RECOVER_MASK;

  // Tables and masks are sized for exactly this fault and channel set
  if (NUM_FAULTS != 17 || NUM_CHANNELS != 16 || IMU_SETTLE == 64'h0 || RECOVERY == 64'h0) begin : g_bad_param
    $error("fsa_fault_state_aggregator: unsupported parameter values");
  end

  logic [16:0]  latched;
  logic [16:0]  prev_active;
  logic [16:0]  next_active;
  logic [63:0]  imu_cnt;
  wire  [16:0]  persist_vec;
  fsa_report_t  next_report;
  fsa_angle_t   next_angle;
  logic [15:0]  az_rom [1:16];
  logic [15:0]  el_rom [1:16];

  // Restart-latched faults hold until reset
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      latched <= 17'h00000;
    end else begin
      latched <= latched | (fault_in & STICKY); // RL7 RL13
    end
  end

  assign next_active = fault_in | latched;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fault_active <= 17'h00000;
      prev_active  <= 17'h00000;
      fault_event  <= 1'b0;
    end else begin
      fault_active <= next_active;
      prev_active  <= next_active;
      fault_event  <= |(next_active & ~prev_active);
    end
  end

  // Recovery timers for self-recovering scan faults
  genvar gi;
  generate
    for (gi = 0; gi < 17; gi++) begin : g_recov
      if (RECOVER[gi]) begin : g_on
        logic [63:0] cnt;
        logic        pers;

        always_ff @(posedge ref_clk or posedge sys_rst) begin
          if (sys_rst) begin
            cnt  <= 64'h0;
            pers <= 1'b0;
          end else if (!fault_in[gi]) begin
            cnt  <= 64'h0;
            pers <= 1'b0;
          end else if (cnt >= RECOVERY - 64'h1) begin
            pers <= 1'b1; // RL9 RL8
          end else begin
            cnt <= cnt + 64'h1; // RL9
          end
        end

        assign persist_vec[gi] = pers;
      end else if (gi == `FSA_IDX_IMU) begin : g_imu
        assign persist_vec[gi] = (imu_cnt >= IMU_SETTLE); // RL6
      end else begin : g_off
        assign persist_vec[gi] = next_active[gi]; // RL15
      end
    end
  endgenerate

  assign fault_persistent = persist_vec;

  // Per-channel design angles, entry 1 is the lowest channel
  genvar ci;
  generate
    for (ci = 1; ci <= 16; ci++) begin : g_chan
      assign az_rom[ci] = AZ_TAB[(16 - ci) * 16 +: 16]; // RL2
      assign el_rom[ci] = EL_TAB[(16 - ci) * 16 +: 16]; // RL2
    end
  endgenerate

  // IMU fault may clear itself inside its settle window
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      imu_cnt <= 64'h0;
    end else if (!fault_in[`FSA_IDX_IMU]) begin
      imu_cnt <= 64'h0;
    end else if (imu_cnt < IMU_SETTLE) begin
      imu_cnt <= imu_cnt + 64'h1; // RL6
    end
  end

  // Health from the most severe active fault
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      health <= FSA_NORMAL;
    end else if (|(next_active & SHUT)) begin
      health <= FSA_SHUTDOWN; // RL3 RL14 RL5 RL7 RL8 RL15
    end else if (|next_active) begin
      health <= FSA_WARNING; // RL3 RL14 RL4 RL10 RL11 RL12
    end else begin
      health <= FSA_NORMAL; // RL14
    end
  end

  // Eye safety shuts all emitters until restart
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      laser_en <= 1'b1;
    end else if (next_active[`FSA_IDX_EYE]) begin
      laser_en <= 1'b0; // RL13
    end
  end

  // Per-fault report lookup, out-of-range selects give zero
  always_comb begin
    next_report = '0;
    if (report_sel < 5'd17) begin
      next_report.code   = CODES[(16 - report_sel) * 16 +: 16]; // RL4 RL5 RL10 RL11 RL12
      next_report.health = SHUT[report_sel] ? FSA_SHUTDOWN : FSA_WARNING;
      next_report.valid  = next_active[report_sel];
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      report <= '0;
    end else begin
      report <= next_report;
    end
  end

  // Channel angles, channel 1 is the lowest
  always_comb begin
    next_angle = '0;
    if (chan_sel >= 5'd1 && chan_sel <= 5'd16) begin
      next_angle.number    = chan_sel; // RL1
      next_angle.azimuth   = az_rom[chan_sel]; // RL2
      next_angle.elevation = el_rom[chan_sel]; // RL2
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      chan_angle <= '0;
    end else begin
      chan_angle <= next_angle;
    end
  end

endmodule : fsa_fault_state_aggregator

// ==== testbench/fsa_fault_state_aggregator_sva.sv ====
// Port assertions for the fault state aggregator
`timescale 1ns/100ps
module fsa_chk import fsa_pkg::*; (
  // Clock, reset and inputs
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic [16:0] fault_in,
  input wire logic [4:0]  chan_sel,
  input wire logic [4:0]  report_sel,
  // Outputs
  input wire fsa_angle_t  chan_angle,
  input wire fsa_report_t report,
  input wire logic [16:0] fault_active,
  input wire logic [16:0] fault_persistent,
  input wire fsa_state_t  health,
  input wire logic        laser_en,
  input wire logic        fault_event
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  new_fault_a: assert property (|(fault_in & ~fault_active) |=> fault_event) else $error("no event");
  track_a: assert property (1 |=> (fault_active & 17'h0FFEF) == ($past(fault_in) & 17'h0FFEF))
    else $error("active mismatch");
  eye_off_a: assert property (fault_active[16] |=> fault_active[16] && !laser_en) else $error("laser on");
  inlet_hold_a: assert property (fault_active[4] |=> fault_active[4]) else $error("inlet cleared");
  health_a: assert property (health == (|(fault_active & 17'h00B96) ? FSA_SHUTDOWN :
    |fault_active ? FSA_WARNING : FSA_NORMAL)) else $error("bad health");
  lens_code_a: assert property (report_sel == 5'h00 |=> report.code == 16'h0104 && report.health == FSA_WARNING)
    else $error("bad lens report");
  chan_num_a: assert property (chan_sel inside {[1:16]} |=> chan_angle.number == $past(chan_sel))
    else $error("bad channel");
  scan_hold_a: assert property ($rose(fault_persistent[6]) |-> $past(fault_active[6], 8))
    else $error("early persist");
endmodule : fsa_chk

bind fsa_fault_state_aggregator fsa_chk u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .fault_in(fault_in),
  .chan_sel(chan_sel), .report_sel(report_sel), .chan_angle(chan_angle), .report(report),
  .fault_active(fault_active), .fault_persistent(fault_persistent), .health(health),
  .laser_en(laser_en), .fault_event(fault_event));

// ==== testbench/fsa_host_model.sv ====
// Host side model counting fault notices
`timescale 1ns/100ps
module fsa_host_model (
  // Clock and fault notice
  input  wire logic ref_clk,
  input  wire logic fault_event,
  // Notices taken
  output int        notices
);
  initial notices = 0;
  always @(posedge ref_clk) if (fault_event) notices <= notices + 1;
endmodule : fsa_host_model

// ==== testbench/test_fault_state_aggregator.sv ====
// Self-checking bench for the fault state aggregator
`timescale 1ns/100ps
module test_fault_state_aggregator import fsa_pkg::*; ;
  logic        ref_clk = 0;
  logic        sys_rst = 1;
  logic [16:0] fault_in = '0;
  logic [4:0]  chan_sel = '0;
  logic [4:0]  report_sel = '0;
  fsa_angle_t  chan_angle;
  fsa_report_t report;
  logic [16:0] fault_active;
  logic [16:0] fault_persistent;
  fsa_state_t  health;
  logic        laser_en;
  logic        fault_event;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          notices;
  logic [15:0] codes [17] = '{16'h0104, 16'h0111, 16'h0112, 16'h0113, 16'h0116, 16'h0117, 16'h0210, 16'h0211,
    16'h0212, 16'h0213, 16'h0214, 16'h0215, 16'h0406, 16'h0407, 16'h0408, 16'h0409, 16'h0501};
  always #2 ref_clk = ~ref_clk;
  fsa_fault_state_aggregator #(.IMU_SETTLE(64'd20), .RECOVERY(64'd50)) DUT (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .fault_in(fault_in), .chan_sel(chan_sel), .chan_angle(chan_angle), .report_sel(report_sel), .report(report),
    .fault_active(fault_active), .fault_persistent(fault_persistent), .health(health), .laser_en(laser_en),
    .fault_event(fault_event));
  fsa_host_model host (.ref_clk(ref_clk), .fault_event(fault_event), .notices(notices));
  function automatic fsa_state_t cls(logic [16:0] f);
    return |(f & 17'h00B96) ? FSA_SHUTDOWN : |f ? FSA_WARNING : FSA_NORMAL;
  endfunction : cls
  task automatic chk(string n, logic [36:0] e, logic [36:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  task automatic rst();
    sys_rst <= 1;
    cyc(16);
    sys_rst <= 0;
  endtask : rst
  task automatic print_verdict();
    if (error_cnt == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  initial begin
    #40000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    logic [16:0] r;
    void'($urandom(32'h3F9B));
    for (int i = 0; i < 17; i++) begin
      rst();
      chk("laser", 1, laser_en);
      @(posedge ref_clk);
      fault_in <= 17'h1 << i;
      report_sel <= 5'(i);
      cyc(1);
      chk("event", 1, fault_event);
      chk("health", cls(17'h1 << i), health);
      cyc(1);
      chk("report", {codes[i], cls(17'h1 << i), 1'b1}, report);
      chk("direct", !(i inside {3, 6, 7, 8, 10}), fault_persistent[i]);
      fault_in <= '0;
      cyc(2);
      chk("latched", i == 4 || i == 16, fault_active[i]);
      chk("laser", i != 16, laser_en);
    end
    for (int c = 0; c < 18; c++) begin
      @(posedge ref_clk);
      chan_sel <= 5'(c);
      report_sel <= 5'($urandom_range(31, 17));
      cyc(2);
      chk("chan", (c > 0 && c < 17) ? c : 0, chan_angle.number);
      chk("refused", 0, report);
      if (c == 1) chk("angle", {16'h4B95, 16'h0001}, chan_angle[31:0]);
      if (c == 16) chk("angle", {16'h498F, 16'h0FB5}, chan_angle[31:0]);
    end
    rst();
    repeat (40) begin
      @(posedge ref_clk);
      r = 17'($urandom) & 17'h0FFEF;
      fault_in <= r;
      cyc(1);
      chk("mix", cls(r), health);
    end
    @(posedge ref_clk);
    fault_in <= '0;
    @(posedge ref_clk);
    @(posedge ref_clk);
    fault_in <= 17'h00048;
    cyc(18);
    chk("persist", 0, fault_persistent & 17'h00048);
    cyc(50);
    chk("persist", 17'h00048, fault_persistent & 17'h00048);
    fault_in <= '0;
    cyc(2);
    chk("cleared", 0, fault_persistent);
    chk("host", 1, notices != 0);
    print_verdict();
  end
endmodule : test_fault_state_aggregator
